// *** verilog/tcc_pkg.sv ***
// ----------------------------------------------------------------------
// Shared constants for the two channel capture/compare timebase.
// ----------------------------------------------------------------------
package tcc_pkg;

   // Data path width of the timer registers.
   localparam int TCC_DW = 16;

   // Register byte offsets.
   localparam logic [7:0] OFS_CONTROL      = 8'h00;
   localparam logic [7:0] OFS_EVENT_GEN    = 8'h14;
   localparam logic [7:0] OFS_CHANNEL_MODE = 8'h18;
   localparam logic [7:0] OFS_ENABLE_POL   = 8'h20;
   localparam logic [7:0] OFS_COUNTER      = 8'h24;
   localparam logic [7:0] OFS_PRESCALE     = 8'h28;
   localparam logic [7:0] OFS_RELOAD       = 8'h2c;
   localparam logic [7:0] OFS_CH1_VALUE    = 8'h34;

   // Control register fields.
   localparam int CTL_COUNT_EN   = 0;
   localparam int CTL_CH1_PRELD  = 1;
   localparam int CTL_LOCK_LO    = 4;
   localparam int CTL_LOCK_HI    = 5;

   // Event generation register fields.
   localparam int EVG_UPDATE     = 0;

   // Enable/polarity register fields, channel 2 sits at a stride of 4.
   localparam int EP_ENABLE      = 0;
   localparam int EP_POLARITY    = 1;
   localparam int EP_STRIDE      = 4;

   // Channel mode register fields, channel 2 sits at a stride of 8.
   localparam int MD_DIR_LO      = 0;
   localparam int MD_DIR_HI      = 1;
   localparam int MD_PSC_LO      = 2;
   localparam int MD_PSC_HI      = 3;
   localparam int MD_STRIDE      = 8;

   // Reset values.
   localparam logic [15:0] RST_ZERO     = 16'h0000;
   localparam logic [15:0] RST_PRESCALE = 16'h0000;
   localparam logic [15:0] RST_RELOAD   = 16'hffff;

   // Channel direction codes.
   localparam logic [1:0] DIR_OUTPUT  = 2'h0;
   localparam logic [1:0] DIR_OWN_PIN = 2'h1;
   localparam logic [1:0] DIR_OTHER   = 2'h2;
   localparam logic [1:0] DIR_TRIGGER = 2'h3;

   // Lowest lock level that freezes the polarity bits.
   localparam logic [1:0] LOCK_POL_MIN = 2'h2;

   // Per-channel configuration as seen by a channel slice.
   typedef struct packed {
      logic       enable;
      logic       polarity;
      logic [1:0] dir;
      logic [1:0] cap_psc;
   } tcc_chan_cfg_t;

endpackage

// *** verilog/tcc_timebase.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Prescaler and up counter with update event generation.
// ----------------------------------------------------------------------
module tcc_timebase
   import tcc_pkg::*;
#(
   parameter int W = TCC_DW
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic         count_en,
   input  wire logic [W-1:0] psc_value,
   input  wire logic [W-1:0] reload,
   input  wire logic         load_en,
   input  wire logic [W-1:0] load_value,
   input  wire logic         sw_update,
   output logic      [W-1:0] cnt,
   output logic              update_pulse
);

   logic [W-1:0] cnt_reg, cnt_next;
   logic [W-1:0] pcnt_reg, pcnt_next;
   logic [W-1:0] pact_reg, pact_next;
   logic         upd_reg, upd_next;

   // The divider ticks once every active prescale plus one cycles.
   always_comb begin
      logic tick;
      logic run;
      logic ovf;
      tick      = (pcnt_reg == pact_reg);                          // RULE9
      run       = count_en && (reload != RST_ZERO[W-1:0]);         // RULE12
      ovf       = 1'b0;
      cnt_next  = cnt_reg;
      pcnt_next = pcnt_reg;
      pact_next = pact_reg;
      if (run) begin
         pcnt_next = tick ? '0 : W'(pcnt_reg + 1'b1);              // RULE9
         if (tick) begin
            if (cnt_reg == reload) begin
               ovf = 1'b1;
            end else begin
               cnt_next = W'(cnt_reg + 1'b1);
            end
         end
      end
      upd_next = ovf | sw_update;
      // An update restarts both counters and loads the new prescale.
      if (upd_next) begin
         cnt_next  = '0;
         pcnt_next = '0;
         pact_next = psc_value;                                    // RULE10
      end
      // A software write to the count beats any counting this cycle.
      if (load_en) begin
         cnt_next = load_value;                                    // RULE20
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         cnt_reg  <= RST_ZERO[W-1:0];
         pcnt_reg <= RST_ZERO[W-1:0];
         pact_reg <= RST_PRESCALE[W-1:0];
         upd_reg  <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         pcnt_reg <= pcnt_next;
         pact_reg <= pact_next;
         upd_reg  <= upd_next;
      end
   end

   assign cnt          = cnt_reg;
   assign update_pulse = upd_reg;

endmodule

// *** verilog/tcc_channel.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// One capture/compare channel: pin output stage and capture front end.
// ----------------------------------------------------------------------
module tcc_channel
   import tcc_pkg::*;
(
   input  wire logic          mclk,
   input  wire logic          rst_b,
   input  tcc_chan_cfg_t      cfg,
   input  wire logic          own_pin,
   input  wire logic          other_pin,
   input  wire logic          trigger_in,
   input  wire logic          compare_reference,
   output logic               channel_compare_out,
   output logic               trigger_out,
   output logic               capture_pulse
);

   logic       out_reg, out_next;
   logic       eff_reg, eff_next;
   logic       cap_reg, cap_next;
   logic [2:0] evc_reg, evc_next;

   // Output stage, edge detect and capture event prescaler.
   always_comb begin
      logic       sel;
      logic       edge_seen;
      logic [2:0] last;
      sel       = 1'b0;
      case (cfg.dir)
         DIR_OWN_PIN: sel = own_pin;                               // RULE17
         DIR_OTHER:   sel = other_pin;
         DIR_TRIGGER: sel = trigger_in;
         default:     sel = 1'b0;
      endcase
      // Polarity 1 inverts, so a falling pin edge becomes a rising one.
      eff_next  = sel ^ cfg.polarity;                              // RULE2
      edge_seen = eff_next & ~eff_reg;                             // RULE2
      last      = 3'((4'h1 << cfg.cap_psc) - 4'h1);
      evc_next  = evc_reg;
      cap_next  = 1'b0;
      out_next  = 1'b0;
      if (cfg.dir == DIR_OUTPUT) begin
         if (cfg.enable) begin                                     // RULE4
            out_next = compare_reference ^ cfg.polarity;       // RULE1 RULE6
         end
      end else if (!cfg.enable) begin
         evc_next = '0;                                            // RULE18
      end else if (edge_seen) begin                                // RULE5
         if (evc_reg >= last) begin
            evc_next = '0;
            cap_next = 1'b1;
         end else begin
            evc_next = 3'(evc_reg + 1'b1);
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         out_reg <= 1'b0;
         eff_reg <= 1'b0;
         cap_reg <= 1'b0;
         evc_reg <= 3'h0;
      end else begin
         out_reg <= out_next;
         eff_reg <= eff_next;
         cap_reg <= cap_next;
         evc_reg <= evc_next;
      end
   end

   assign channel_compare_out = out_reg;
   assign trigger_out         = eff_reg;
   assign capture_pulse       = cap_reg;

endmodule

// *** verilog/tcc_top.sv ***
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// Two channel capture/compare timebase, register slave and channels.
// ----------------------------------------------------------------------
// How it works
// RULE1 - Output mode: polarity 0 gives active high output, 1 active low.
// RULE2 - Input mode: polarity 0 captures rising edges, 1 falling, inverted.
// RULE3 - Lock level 2 or 3 makes polarity bits ignore software writes.
// RULE4 - Output mode: enable 0 turns compare output off, 1 on.
// RULE5 - Input mode: enable bit gates the capture function.
// RULE6 - Disabled output drives 0; enabled drives reference xor polarity.
// RULE7 - Enables and polarities sit at bits 0, 1, 4 and 5.
// RULE8 - Software keeps reserved enable/polarity bits at reset value.
// RULE9 - Counter advances once per prescale value plus one cycles.
// RULE10 - Written prescale takes effect only at an update event.
// RULE11 - Reload register feeds the counter wrap value, resets all ones.
// RULE12 - A zero reload value stops the counter.
// RULE13 - Output mode: channel 1 value compared with counter.
// RULE14 - Preload off: compare value active at once; on: at update.
// RULE15 - Input mode: channel 1 capture copies the counter value.
// RULE16 - Channel 1 value register read-only in input mode.
// RULE17 - Direction field: output, own pin, other pin, internal trigger.
// RULE18 - Disabled channel holds its capture event prescaler in reset.
// RULE19 - Direction field writable only while channel enable is 0.
// RULE20 - Counter readable and writable at any time, write loads it.
module tcc_top
   import tcc_pkg::*;
#(
   parameter int W = TCC_DW
) (
   input  wire logic        mclk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [31:0] reg_rdata,
   input  wire logic        ch1_capture_in,
   input  wire logic        ch2_capture_in,
   input  wire logic        trigger_in,
   input  wire logic        ch2_compare_reference,
   output logic             ch1_compare_out,
   output logic             ch2_compare_out,
   output logic             ch1_trigger_out,
   output logic             ch2_trigger_out,
   output logic             update_event
);

   // ----------------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------------
   logic         count_en_reg, count_en_next;
   logic         ch1_preload_enable_reg, ch1_preload_enable_next;
   logic [1:0]   lock_level_reg, lock_level_next;
   logic [1:0]   enable_reg, enable_next;
   logic [1:0]   polarity_reg, polarity_next;
   logic [1:0]   dir_reg [2];
   logic [1:0]   dir_next [2];
   logic [1:0]   cap_psc_reg [2];
   logic [1:0]   cap_psc_next [2];
   logic [W-1:0] prescale_value_reg, prescale_value_next;
   logic [W-1:0] reload_value_reg, reload_value_next;
   logic [W-1:0] ch1_value_reg, ch1_value_next;
   logic [W-1:0] ch1_active_reg, ch1_active_next;
   logic [31:0]  rdata_reg, rdata_next;

   // ----------------------------------------------------------------------
   // Wires between the register file, timebase and channels
   // ----------------------------------------------------------------------
   logic          wr_ctl, wr_evg, wr_mode, wr_ep;
   logic          wr_cnt, wr_psc, wr_rel, wr_ch1;
   logic [W-1:0]  cnt;
   logic          upd_pulse;
   logic          sw_update;
   logic          ch1_reference;
   tcc_chan_cfg_t cfg [2];
   logic [1:0]    pin_in;
   logic [1:0]    ref_in;
   logic [1:0]    cmp_out;
   logic [1:0]    trg_out;
   logic [1:0]    cap_pulse;

   // ----------------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------------

   // Each write strobe selects at most one register; others are dropped.
   always_comb begin
      wr_ctl  = 1'b0;
      wr_evg  = 1'b0;
      wr_mode = 1'b0;
      wr_ep   = 1'b0;
      wr_cnt  = 1'b0;
      wr_psc  = 1'b0;
      wr_rel  = 1'b0;
      wr_ch1  = 1'b0;
      if (!reg_write) begin
         wr_ctl = 1'b0;
      end else if (reg_addr == OFS_CONTROL) begin
         wr_ctl = 1'b1;
      end else if (reg_addr == OFS_EVENT_GEN) begin
         wr_evg = 1'b1;
      end else if (reg_addr == OFS_CHANNEL_MODE) begin
         wr_mode = 1'b1;
      end else if (reg_addr == OFS_ENABLE_POL) begin
         wr_ep = 1'b1;
      end else if (reg_addr == OFS_COUNTER) begin
         wr_cnt = 1'b1;
      end else if (reg_addr == OFS_PRESCALE) begin
         wr_psc = 1'b1;
      end else if (reg_addr == OFS_RELOAD) begin
         wr_rel = 1'b1;
      end else if (reg_addr == OFS_CH1_VALUE) begin
         wr_ch1 = 1'b1;
      end
   end

   // The software update bit is a self clearing command, never stored.
   assign sw_update = wr_evg & reg_wdata[EVG_UPDATE];

   // ----------------------------------------------------------------------
   // Control, mode and enable/polarity registers
   // ----------------------------------------------------------------------

   // Reserved bits are not stored, so they always read back as zero.
   always_comb begin
      count_en_next           = count_en_reg;
      ch1_preload_enable_next = ch1_preload_enable_reg;
      lock_level_next         = lock_level_reg;
      enable_next             = enable_reg;
      polarity_next           = polarity_reg;
      if (wr_ctl) begin
         count_en_next           = reg_wdata[CTL_COUNT_EN];
         ch1_preload_enable_next = reg_wdata[CTL_CH1_PRELD];
         lock_level_next         = reg_wdata[CTL_LOCK_HI:CTL_LOCK_LO];
      end
      for (int i = 0; i < 2; i++) begin
         dir_next[i]     = dir_reg[i];
         cap_psc_next[i] = cap_psc_reg[i];
         if (wr_mode) begin
            // Direction changes only while the channel is switched off.
            if (!enable_reg[i]) begin                              // RULE19
               dir_next[i] = reg_wdata[i*MD_STRIDE+MD_DIR_LO +: 2];
            end
            cap_psc_next[i] = reg_wdata[i*MD_STRIDE+MD_PSC_LO +: 2];
         end
         if (wr_ep) begin
            enable_next[i] = reg_wdata[i*EP_STRIDE+EP_ENABLE];     // RULE7
            // Locked polarity bits silently keep their old value.
            if (lock_level_reg < LOCK_POL_MIN) begin               // RULE3
               polarity_next[i] = reg_wdata[i*EP_STRIDE+EP_POLARITY];
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         count_en_reg           <= 1'b0;
         ch1_preload_enable_reg <= 1'b0;
         lock_level_reg         <= 2'h0;
         enable_reg             <= 2'h0;
         polarity_reg           <= 2'h0;
         for (int i = 0; i < 2; i++) begin
            dir_reg[i]     <= DIR_OUTPUT;
            cap_psc_reg[i] <= 2'h0;
         end
      end else begin
         count_en_reg           <= count_en_next;
         ch1_preload_enable_reg <= ch1_preload_enable_next;
         lock_level_reg         <= lock_level_next;
         enable_reg             <= enable_next;
         polarity_reg           <= polarity_next;
         for (int i = 0; i < 2; i++) begin
            dir_reg[i]     <= dir_next[i];
            cap_psc_reg[i] <= cap_psc_next[i];
         end
      end
   end

   // ----------------------------------------------------------------------
   // Prescale, reload and channel 1 value registers
   // ----------------------------------------------------------------------

   // Capture in input mode and software write in output mode never meet,
   // because the same direction field chooses between them.
   always_comb begin
      prescale_value_next = prescale_value_reg;
      reload_value_next   = reload_value_reg;
      ch1_value_next      = ch1_value_reg;
      ch1_active_next     = ch1_active_reg;
      if (wr_psc) begin
         prescale_value_next = reg_wdata[W-1:0];                   // RULE10
      end
      if (wr_rel) begin
         reload_value_next = reg_wdata[W-1:0];                     // RULE11
      end
      if (dir_reg[0] == DIR_OUTPUT) begin
         if (wr_ch1) begin                                         // RULE16
            ch1_value_next = reg_wdata[W-1:0];
            if (!ch1_preload_enable_reg) begin
               ch1_active_next = reg_wdata[W-1:0];                 // RULE14
            end
         end
         if (upd_pulse && ch1_preload_enable_reg) begin
            ch1_active_next = ch1_value_reg;                       // RULE14
         end
      end else if (cap_pulse[0]) begin
         ch1_value_next = cnt;                                     // RULE15
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         prescale_value_reg <= RST_PRESCALE[W-1:0];
         reload_value_reg   <= RST_RELOAD[W-1:0];
         ch1_value_reg      <= RST_ZERO[W-1:0];
         ch1_active_reg     <= RST_ZERO[W-1:0];
      end else begin
         prescale_value_reg <= prescale_value_next;
         reload_value_reg   <= reload_value_next;
         ch1_value_reg      <= ch1_value_next;
         ch1_active_reg     <= ch1_active_next;
      end
   end

   // ----------------------------------------------------------------------
   // Read data, valid in the cycle after the read strobe
   // ----------------------------------------------------------------------

   // Unmapped addresses and write-only commands return zero.
   always_comb begin
      rdata_next = 32'h0000_0000;
      if (!reg_read) begin
         rdata_next = 32'h0000_0000;
      end else if (reg_addr == OFS_CONTROL) begin
         rdata_next[CTL_COUNT_EN]            = count_en_reg;
         rdata_next[CTL_CH1_PRELD]           = ch1_preload_enable_reg;
         rdata_next[CTL_LOCK_HI:CTL_LOCK_LO] = lock_level_reg;
      end else if (reg_addr == OFS_CHANNEL_MODE) begin
         for (int i = 0; i < 2; i++) begin
            rdata_next[i*MD_STRIDE+MD_DIR_LO +: 2] = dir_reg[i];
            rdata_next[i*MD_STRIDE+MD_PSC_LO +: 2] = cap_psc_reg[i];
         end
      end else if (reg_addr == OFS_ENABLE_POL) begin
         for (int i = 0; i < 2; i++) begin
            rdata_next[i*EP_STRIDE+EP_ENABLE]   = enable_reg[i];   // RULE7
            rdata_next[i*EP_STRIDE+EP_POLARITY] = polarity_reg[i];
         end
      end else if (reg_addr == OFS_COUNTER) begin
         rdata_next[W-1:0] = cnt;                                  // RULE20
      end else if (reg_addr == OFS_PRESCALE) begin
         rdata_next[W-1:0] = prescale_value_reg;
      end else if (reg_addr == OFS_RELOAD) begin
         rdata_next[W-1:0] = reload_value_reg;
      end else if (reg_addr == OFS_CH1_VALUE) begin
         rdata_next[W-1:0] = ch1_value_reg;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rdata_reg <= 32'h0000_0000;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   assign reg_rdata = rdata_reg;

   // ----------------------------------------------------------------------
   // Timebase
   // ----------------------------------------------------------------------
   tcc_timebase #(
      .W (W)
   ) u_timebase (
      .mclk         (mclk),
      .rst_b        (rst_b),
      .count_en     (count_en_reg),
      .psc_value    (prescale_value_reg),
      .reload       (reload_value_reg),                            // RULE11
      .load_en      (wr_cnt),
      .load_value   (reg_wdata[W-1:0]),
      .sw_update    (sw_update),
      .cnt          (cnt),
      .update_pulse (upd_pulse)
   );

   // Reference is high while the count is below the active compare value.
   assign ch1_reference = (cnt < ch1_active_reg);                  // RULE13

   // ----------------------------------------------------------------------
   // Channels; each sees the other's pin for cross mapping
   // ----------------------------------------------------------------------
   assign pin_in = {ch2_capture_in, ch1_capture_in};
   assign ref_in = {ch2_compare_reference, ch1_reference};

   for (genvar g = 0; g < 2; g++) begin : g_chan
      assign cfg[g] = '{enable:   enable_reg[g],
                        polarity: polarity_reg[g],
                        dir:      dir_reg[g],
                        cap_psc:  cap_psc_reg[g]};
      tcc_channel u_channel (
         .mclk                (mclk),
         .rst_b               (rst_b),
         .cfg                 (cfg[g]),
         .own_pin             (pin_in[g]),
         .other_pin           (pin_in[1-g]),
         .trigger_in          (trigger_in),
         .compare_reference   (ref_in[g]),
         .channel_compare_out (cmp_out[g]),
         .trigger_out         (trg_out[g]),
         .capture_pulse       (cap_pulse[g])
      );
   end

   // All of these come straight from flip-flops, in the channel slices or the timebase.
   assign ch1_compare_out = cmp_out[0];
   assign ch2_compare_out = cmp_out[1];
   assign ch1_trigger_out = trg_out[0];
   assign ch2_trigger_out = trg_out[1];
   assign update_event    = upd_pulse;

endmodule

// *** sim/tcc_pin_model.sv ***
`timescale 1ns/1ps
// ----
// Far side pins.
// ----
module tcc_pin_model (
   input  wire logic       mclk,
   input  wire logic [3:0] pin_req,
   output logic      [3:0] pins
);
   // Registered, as a real driver would be; never glitches mid-cycle.
   always_ff @(posedge mclk) pins <= pin_req;
endmodule

// *** sim/tcc_top_asserts.sv ***
`timescale 1ns/1ps
// ----
// Port checker, software view shadow.
// ----
module tcc_top_asserts (
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic [7:0]  reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic        reg_write,
   input wire logic        reg_read,
   input wire logic [31:0] reg_rdata,
   input wire logic        ch1_capture_in,
   input wire logic        ch2_capture_in,
   input wire logic        trigger_in,
   input wire logic        ch2_compare_reference,
   input wire logic        ch1_compare_out,
   input wire logic        ch2_compare_out,
   input wire logic        ch2_trigger_out,
   input wire logic        update_event
);
   logic [1:0]  en, pol, lk, d2;
   logic [15:0] rl;
   // Shadow of the software view; old values gate writes.
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         en <= 2'h0;
         pol <= 2'h0;
         lk <= 2'h0;
         d2 <= 2'h0;
         rl <= 16'hffff;
      end else if (reg_write) begin
         if (reg_addr == 8'h20) en <= {reg_wdata[4], reg_wdata[0]};
         if (reg_addr == 8'h20 && lk < 2'h2)
            pol <= {reg_wdata[5], reg_wdata[1]};
         if (reg_addr == 8'h00) lk <= reg_wdata[5:4];
         if (reg_addr == 8'h18 && !en[1]) d2 <= reg_wdata[9:8];
         if (reg_addr == 8'h2c) rl <= reg_wdata[15:0];
      end
   end
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   chk_ch1_off_low: assert property (!en[0] |=> !ch1_compare_out)
      else $error("ch1 high off");
   chk_ch2_off_low: assert property (!en[1] |=> !ch2_compare_out)
      else $error("ch2 high off");
   chk_ch2_out_pol: assert property (en[1] && d2 == 2'h0 |=>
      ch2_compare_out == ($past(ch2_compare_reference) ^ $past(pol[1])))
      else $error("ch2 out pol");
   chk_trig_own_pin: assert property (d2 == 2'h1 |=>
      ch2_trigger_out == ($past(ch2_capture_in) ^ $past(pol[1])))
      else $error("trig own");
   chk_trig_other_pin: assert property (d2 == 2'h2 |=>
      ch2_trigger_out == ($past(ch1_capture_in) ^ $past(pol[1])))
      else $error("trig other");
   chk_trig_internal: assert property (d2 == 2'h3 |=>
      ch2_trigger_out == ($past(trigger_in) ^ $past(pol[1])))
      else $error("trig internal");
   chk_ep_read_map: assert property (reg_read && reg_addr == 8'h20 |=>
      reg_rdata == {26'h0, pol[1], en[1], 2'h0, pol[0], en[0]})
      else $error("ep read");
   chk_reload_zero: assert property (rl == 16'h0 &&
      $past(rl, 2) == 16'h0 && !$past(reg_write) &&
      !$past(reg_write, 2) |-> !update_event)
      else $error("zero reload upd");
   cover property (update_event);
   cover property (en[1] && d2 == 2'h0 && ch2_compare_reference);
   cover property (d2 == 2'h3 && trigger_in);
endmodule
bind tcc_top tcc_top_asserts tcc_top_asserts_i (.*);

// *** sim/tb_tcc_top.sv ***
`timescale 1ns/1ps
// ----
// Register and pin tests.
// ----
module tb_tcc_top;
   logic        mclk, rst_b, reg_write, reg_read, c1o, c2o;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata, reg_rdata, v;
   logic [3:0]  pin_req, pins;
   int          err_count, compares;
   tcc_top tcc_top_i (.*,
      .ch1_capture_in(pins[0]), .ch2_capture_in(pins[1]),
      .trigger_in(pins[2]), .ch2_compare_reference(pins[3]),
      .ch1_compare_out(c1o), .ch2_compare_out(c2o),
      .ch1_trigger_out(), .ch2_trigger_out(), .update_event());
   tcc_pin_model tcc_pin_model_i (.*);
   // 200 MHz clock.
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   // Each access spans two edges.
   task automatic chk(input logic ok, input string m);
      compares++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("BAD t=%0t %s", $time, m);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      reg_addr <= a;
      reg_wdata <= {16'h0, d};
      reg_write <= 1'b1;
      @(posedge mclk);
      reg_write <= 1'b0;
      @(posedge mclk);
   endtask
   // Read data stand only in the cycle after the strobe edge.
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_read <= 1'b1;
      @(posedge mclk);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
      @(posedge mclk);
   endtask
   task automatic rdx(input logic [7:0] a, input logic [15:0] e,
                      input string m);
      rd(a);
      chk(v === {16'h0, e}, m);
   endtask
   // Count advance over eight cycles.
   task automatic rate(input logic [15:0] e, input string m);
      logic [15:0] a;
      rd(8'h24);
      a = v[15:0];
      repeat (6) @(posedge mclk);
      rd(8'h24);
      chk(v[15:0] - a === e, m);
   endtask
   task automatic pin(input logic [3:0] p);
      pin_req <= p;
      repeat (5) @(posedge mclk);
   endtask
   task automatic close_out();
      $display("compares=%0d err_count=%0d", compares, err_count);
      if (err_count == 0 && compares > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog: a hang counts as a mismatch.
   initial begin
      repeat (20000) @(posedge mclk);
      err_count++;
      close_out();
   end
   // Main sequence.
   initial begin
      err_count = 0;
      compares = 0;
      rst_b = 1'b0;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_addr = 8'h0;
      reg_wdata = 32'h0;
      pin_req = 4'h0;
      repeat (8) @(posedge mclk);
      rst_b <= 1'b1;
      @(posedge mclk);
      rdx(8'h28, 16'h0, "psc rst");
      rdx(8'h2c, 16'hffff, "rel rst");
      rdx(8'h30, 16'h0, "unmapped");
      $display("test reset done");
      wr(8'h20, 16'h0033);
      rdx(8'h20, 16'h0033, "ep map");
      pin(4'h8);
      chk(c2o === 1'b0, "pol hi ref");
      pin(4'h0);
      chk(c2o === 1'b1, "pol lo ref");
      for (int l = 2; l < 4; l++) begin
         wr(8'h00, {10'h0, l[1:0], 4'h0});
         wr(8'h20, 16'h0000);
         rdx(8'h20, 16'h0022, "lock");
      end
      wr(8'h00, 16'h0);
      wr(8'h20, 16'h0);
      $display("test enable done");
      wr(8'h28, 16'h3);
      wr(8'h00, 16'h1);
      rate(16'h8, "psc held");
      wr(8'h14, 16'h1);
      rate(16'h2, "div4");
      wr(8'h28, 16'h0);
      wr(8'h14, 16'h1);
      wr(8'h2c, 16'h3);
      rate(16'h0, "wrap");
      wr(8'h2c, 16'h0);
      rate(16'h0, "zero rel");
      wr(8'h00, 16'h0);
      wr(8'h24, 16'h1234);
      rdx(8'h24, 16'h1234, "cnt load");
      $display("test timebase done");
      wr(8'h20, 16'h1);
      wr(8'h34, 16'h1235);
      pin(4'h0);
      chk(c1o === 1'b1, "below");
      wr(8'h34, 16'h1234);
      pin(4'h0);
      chk(c1o === 1'b0, "equal");
      wr(8'h34, 16'h1235);
      wr(8'h00, 16'h2);
      wr(8'h34, 16'h0);
      pin(4'h0);
      chk(c1o === 1'b1, "pre held");
      wr(8'h14, 16'h1);
      pin(4'h0);
      chk(c1o === 1'b0, "pre moved");
      $display("test compare done");
      wr(8'h20, 16'h0);
      wr(8'h00, 16'h0);
      wr(8'h18, 16'h1);
      wr(8'h24, 16'h55);
      pin(4'h1);
      rdx(8'h34, 16'h0, "cap off");
      wr(8'h34, 16'h77);
      rdx(8'h34, 16'h0, "ro value");
      pin(4'h0);
      wr(8'h20, 16'h1);
      pin(4'h1);
      rdx(8'h34, 16'h55, "rise cap");
      wr(8'h20, 16'h3);
      wr(8'h24, 16'h66);
      pin(4'h0);
      rdx(8'h34, 16'h66, "fall cap");
      wr(8'h24, 16'h99);
      pin(4'h1);
      rdx(8'h34, 16'h66, "no rise");
      for (int m = 1; m < 4; m++) begin
         wr(8'h18, {6'h0, m[1:0], 8'h1});
         pin(4'h7);
         pin(4'h0);
      end
      $display("test capture done");
      close_out();
   end
endmodule
